/* core/adcc_top.sv */
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
// Behaviour
// - Writing 1 to control bit 7 with bit 4 set in the same write starts a conversion; it reads 1 while busy.
// - A start during a running conversion abandons it and begins anew.
// - Control bit 5 switches the reference buffer on, else external reference.
// - Control bits 2 to 0 select analog input n for code n.
// - High byte register shows result bits 9 to 2, read-only.
// - Reading the high byte latches the two low result bits.
// - Result holds until the next conversion completes, then updates.
// - Low bits register shows the two low bits in bits 7 and 6.
// - Completion raises an interrupt; disabling the converter does not clear it.
module adcc_top
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [9:0] conv_result,
  output adcc_pkg::adcc_afe_t afe,
  output logic irq
);
  import adcc_pkg::*;

  adcc_top_t s_reg;
  adcc_top_t s_next;
  logic busy;
  logic sample_hold;
  logic done;
  logic start;
  logic req;
  logic [11:0] req_idx;
  logic w1c;
  adcc_top_t view;
  adcc_ctrl_t wr_ctrl;

  function automatic logic [7:0] read_byte(
    input logic [11:0] idx,
    input adcc_top_t s,
    input logic bsy
  );
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      IDX_CTRL: b = {bsy, s.ctrl.rsv6, s.ctrl.reference_buffer_enable,
                     s.ctrl.converter_enable, s.ctrl.rsv3, s.ctrl.channel_select};
      IDX_HIGH: b = s.result[9:2];
      IDX_LOW: b = {s.low_latch, 6'h00};
      IDX_IRQ_STAT: b = {7'h00, s.irq_stat};
      IDX_IRQ_MASK: b = {7'h00, s.irq_mask};
      default: b = 8'h00;
    endcase
    return b;
  endfunction : read_byte

  assign req = hsel && htrans[1] && hready;
  assign req_idx = haddr[IDX_MSB:IDX_LSB];
  assign wr_ctrl = adcc_ctrl_t'(hwdata[7:0]);

  always_comb
  begin
    s_next = s_reg;
    start = 1'b0;
    w1c = 1'b0;
    s_next.wr_pend = req && hwrite;
    s_next.idx = req_idx;
    s_next.hrdata = 32'h0000_0000;
    if (s_reg.wr_pend)
    begin
      case (s_reg.idx)
        IDX_CTRL:
        begin
          // Reserved bits are stored as written; software keeps them 0
          s_next.ctrl = adcc_ctrl_t'(hwdata[7:0]);
          s_next.ctrl.start = 1'b0;
          start = hwdata[START_POS] && hwdata[ENABLE_POS];
        end
        IDX_IRQ_STAT: w1c = hwdata[IRQ_DONE_POS];
        IDX_IRQ_MASK: s_next.irq_mask = hwdata[IRQ_DONE_POS];
        default: ;
      endcase
    end
    if (done)
      s_next.result = conv_result;
    // Set wins over a same-cycle clear; disabling never clears it
    s_next.irq_stat = (s_reg.irq_stat && !w1c) || done;
    // A write in its data phase already shows to a read in the same cycle; busy lags one cycle
    view = s_reg;
    view.ctrl = s_next.ctrl;
    view.irq_stat = s_next.irq_stat;
    view.irq_mask = s_next.irq_mask;
    if (req && !hwrite)
    begin
      s_next.hrdata = {24'h000000, read_byte(req_idx, view, busy)};
      if (req_idx == IDX_HIGH)
        s_next.low_latch = s_reg.result[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_reg <= '0;
      s_reg.ctrl <= adcc_ctrl_t'(CTRL_RESET);
      s_reg.result <= RESULT_RESET;
    end
    else
      s_reg <= s_next;
  end

  adcc_conv_seq u_seq
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(start),
    .enable(s_next.ctrl.converter_enable),
    .busy(busy),
    .sample_hold(sample_hold),
    .done(done)
  );

  // Zero wait states: read data is prepared in the address phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_reg.hrdata;
  assign irq = s_reg.irq_stat && s_reg.irq_mask;
  always_comb
  begin
    afe.reference_buffer_enable = s_reg.ctrl.reference_buffer_enable;
    afe.converter_enable = s_reg.ctrl.converter_enable;
    afe.channel_select = s_reg.ctrl.channel_select;
    afe.sample_hold = sample_hold;
  end

  property p_high_ro;
    @(posedge hclk) disable iff (!hresetn)
    (s_reg.wr_pend && s_reg.idx == IDX_HIGH && !done) |=> $stable(s_reg.result);
  endproperty
  a_high_ro: assert property (p_high_ro) else $error("high byte changed on write");

  property p_low_latch;
    @(posedge hclk) disable iff (!hresetn)
    (req && !hwrite && req_idx == IDX_HIGH) |=> (s_reg.low_latch == $past(s_reg.result[1:0])
      && s_reg.hrdata[7:0] == $past(s_reg.result[9:2]));
  endproperty
  a_low_latch: assert property (p_low_latch) else $error("low bits not latched");

  property p_hold;
    @(posedge hclk) disable iff (!hresetn)
    !done |=> $stable(s_reg.result);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed without completion");

  property p_update;
    @(posedge hclk) disable iff (!hresetn)
    done |=> (s_reg.result == $past(conv_result));
  endproperty
  a_update: assert property (p_update) else $error("result not updated");

  property p_irq_set;
    @(posedge hclk) disable iff (!hresetn)
    (done && s_reg.irq_mask) |=> (s_reg.irq_stat && irq);
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("completion raised no interrupt");

  property p_irq_keep;
    @(posedge hclk) disable iff (!hresetn)
    (s_reg.irq_stat && !(s_reg.wr_pend && s_reg.idx == IDX_IRQ_STAT)) |=> s_reg.irq_stat;
  endproperty
  a_irq_keep: assert property (p_irq_keep) else $error("pending interrupt lost");

  property p_busy_read;
    @(posedge hclk) disable iff (!hresetn)
    (req && !hwrite && req_idx == IDX_CTRL) |=> (s_reg.hrdata[START_POS] == $past(busy));
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("start bit readback wrong");

  property p_chan_route;
    @(posedge hclk) disable iff (!hresetn)
    (s_reg.wr_pend && s_reg.idx == IDX_CTRL)
      |=> (afe.channel_select == $past(wr_ctrl.channel_select));
  endproperty
  a_chan_route: assert property (p_chan_route) else $error("channel select not routed");

  property p_ref_ctrl;
    @(posedge hclk) disable iff (!hresetn)
    (s_reg.wr_pend && s_reg.idx == IDX_CTRL)
      |=> (afe.reference_buffer_enable == $past(wr_ctrl.reference_buffer_enable));
  endproperty
  a_ref_ctrl: assert property (p_ref_ctrl) else $error("reference select not applied");

  property p_start_off;
    @(posedge hclk) disable iff (!hresetn)
    (s_reg.wr_pend && s_reg.idx == IDX_CTRL && !wr_ctrl.converter_enable) |=> !busy;
  endproperty
  a_start_off: assert property (p_start_off) else $error("converter ran while disabled");

  property p_irq_clear;
    @(posedge hclk) disable iff (!hresetn)
    (s_reg.wr_pend && s_reg.idx == IDX_IRQ_STAT && hwdata[IRQ_DONE_POS] && !done)
      |=> (!s_reg.irq_stat && !irq);
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("status bit not cleared");

  property p_low_read;
    @(posedge hclk) disable iff (!hresetn)
    (req && !hwrite && req_idx == IDX_LOW)
      |=> (s_reg.hrdata == {24'h000000, $past(s_reg.low_latch), 6'h00});
  endproperty
  a_low_read: assert property (p_low_read) else $error("low bits misplaced");

  c_pending_off: cover property (@(posedge hclk) disable iff (!hresetn)
    s_reg.irq_stat && !s_reg.ctrl.converter_enable);
  c_high_then_low: cover property (@(posedge hclk) disable iff (!hresetn)
    (req && !hwrite && req_idx == IDX_HIGH) ##1 (req && !hwrite && req_idx == IDX_LOW));
  c_irq: cover property (@(posedge hclk) disable iff (!hresetn) irq);
endmodule : adcc_top

/* core/adcc_pkg.sv */
package adcc_pkg;

  // Register indices; the bus byte address is four times the index
  localparam logic [11:0] IDX_CTRL = 12'hF70;
  localparam logic [11:0] IDX_HIGH = 12'hF72;
  localparam logic [11:0] IDX_LOW = 12'hF73;
  localparam logic [11:0] IDX_IRQ_STAT = 12'hF78;
  localparam logic [11:0] IDX_IRQ_MASK = 12'hF79;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 13;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam int START_POS = 7;
  localparam int ENABLE_POS = 4;
  localparam int LOW_PAD = 6;
  localparam int IRQ_DONE_POS = 0;

  // Conversion timing at 25 MHz
  localparam int CLK_PERIOD_NS = 40;
  localparam int SAMPLE_NS = 1000;
  localparam int SETTLE_NS = 500;
  localparam int CONV_ADCLK = 13;
  localparam int ADCLK_DIV = 16;
  localparam logic [7:0] SAMPLE_CYC =
    8'((SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] SETTLE_CYC =
    8'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] CONV_CYC = 8'(CONV_ADCLK * ADCLK_DIV);

  typedef struct packed {
    logic start;
    logic rsv6;
    logic reference_buffer_enable;
    logic converter_enable;
    logic rsv3;
    logic [2:0] channel_select;
  } adcc_ctrl_t;

  typedef struct packed {
    logic reference_buffer_enable;
    logic converter_enable;
    logic [2:0] channel_select;
    logic sample_hold;
  } adcc_afe_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_SETTLE = 2'b11,
    ST_CONVERT = 2'b10
  } adcc_state_t;

  typedef struct packed {
    adcc_state_t state;
    logic [7:0] cnt;
    logic done;
  } adcc_seq_t;

  typedef struct packed {
    adcc_ctrl_t ctrl;
    logic [9:0] result;
    logic [1:0] low_latch;
    logic irq_stat;
    logic irq_mask;
    logic wr_pend;
    logic [11:0] idx;
    logic [31:0] hrdata;
  } adcc_top_t;

endpackage : adcc_pkg

/* core/adcc_conv_seq.sv */
`timescale 1ns/1ns
module adcc_conv_seq
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic enable,
  output logic busy,
  output logic sample_hold,
  output logic done
);
  import adcc_pkg::*;

  adcc_seq_t s_reg;
  adcc_seq_t s_next;

  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (!enable)
    begin
      s_next.state = ST_IDLE;
      s_next.cnt = 8'h00;
    end
    else if (start)
    begin
      // A new start abandons whatever is running
      s_next.state = ST_SAMPLE;
      s_next.cnt = SAMPLE_CYC - 8'h01;
    end
    else
    begin
      case (s_reg.state)
        ST_SAMPLE:
        begin
          s_next.cnt = s_reg.cnt - 8'h01;
          if (s_reg.cnt == 8'h00)
          begin
            s_next.state = ST_SETTLE;
            s_next.cnt = SETTLE_CYC - 8'h01;
          end
        end
        ST_SETTLE:
        begin
          s_next.cnt = s_reg.cnt - 8'h01;
          if (s_reg.cnt == 8'h00)
          begin
            s_next.state = ST_CONVERT;
            s_next.cnt = CONV_CYC - 8'h01;
          end
        end
        ST_CONVERT:
        begin
          s_next.cnt = s_reg.cnt - 8'h01;
          if (s_reg.cnt == 8'h00)
          begin
            s_next.state = ST_IDLE;
            s_next.done = 1'b1;
          end
        end
        default:
        begin
          s_next.state = ST_IDLE;
          s_next.cnt = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign busy = (s_reg.state != ST_IDLE);
  assign sample_hold = (s_reg.state == ST_SAMPLE);
  assign done = s_reg.done;

  property p_start_busy;
    @(posedge hclk) disable iff (!hresetn)
    (start && enable) |=> busy ##1 busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start did not set busy");

  property p_restart;
    @(posedge hclk) disable iff (!hresetn)
    (busy && start && enable) |=> (s_reg.state == ST_SAMPLE && s_reg.cnt == SAMPLE_CYC - 8'h01);
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not reload sampling");

  property p_disable;
    @(posedge hclk) disable iff (!hresetn)
    !enable |=> !busy;
  endproperty
  a_disable: assert property (p_disable) else $error("busy while disabled");

  property p_conv_end;
    @(posedge hclk) disable iff (!hresetn)
    (s_reg.state == ST_CONVERT && s_reg.cnt == 8'h00 && enable && !start) |=> (done && !busy);
  endproperty
  a_conv_end: assert property (p_conv_end) else $error("conversion end missed");

  c_full_conv: cover property (@(posedge hclk) disable iff (!hresetn) done);
  c_restart: cover property (@(posedge hclk) disable iff (!hresetn) busy && start && enable);
endmodule : adcc_conv_seq

/* verification/adcc_tb.sv */
`timescale 1ns/1ns
module testbench;
  import adcc_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [9:0] conv_result = 10'h2D6;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  adcc_afe_t afe;
  logic irq;
  logic [31:0] rd;
  int num_errors = 0;
  int check_count = 0;

  always #20 hclk = ~hclk;

  adcc_top DUT
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .conv_result(conv_result),
    .afe(afe),
    .irq(irq)
  );

  task automatic tally_and_finish();
    if (num_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Data is taken at the edge that sees ready; an error response poisons it
  task automatic wait_rdy();
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    rd = hresp ? 32'hFFFF_FFFF : hrdata;
  endtask : wait_rdy

  task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {18'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
  endtask : xfer

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, {24'h0, d});
  endtask : wr

  task automatic rdc(input logic [11:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk(rd, {24'h0, exp});
  endtask : rdc

  task automatic t_ctrl();
    rdc(IDX_CTRL, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      wr(IDX_CTRL, 8'h20 | 8'(c));
      rdc(IDX_CTRL, 8'h20 | 8'(c));
      chk({26'h0, afe}, {26'h0, 2'b10, 3'(c), 1'b0});
    end
    // Start with the converter off must be ignored
    wr(IDX_CTRL, 8'h80);
    rdc(IDX_CTRL, 8'h00);
    chk({26'h0, afe}, 32'h0);
  endtask : t_ctrl

  task automatic t_conv();
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_CTRL, 8'h93);
    @(negedge hclk);
    chk({31'h0, afe.sample_hold}, 32'h1);
    chk({31'h0, afe.converter_enable}, 32'h1);
    @(posedge hclk);
    rdc(IDX_CTRL, 8'h93);
    repeat (100) @(posedge hclk);
    // Restart; the first run would have ended well before 240 cycles from here
    wr(IDX_CTRL, 8'h93);
    repeat (240) @(posedge hclk);
    @(negedge hclk);
    chk({31'h0, irq}, 32'h0);
    repeat (12) @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    conv_result <= 10'h155;
    rdc(IDX_HIGH, 8'hB5);
    rdc(IDX_LOW, 8'h80);
    wr(IDX_HIGH, 8'hFF);
    rdc(IDX_HIGH, 8'hB5);
    rdc(12'h000, 8'h00);
  endtask : t_conv

  task automatic t_irq();
    wr(IDX_CTRL, 8'h03);
    rdc(IDX_IRQ_STAT, 8'h01);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_MASK, 8'h00);
    rdc(IDX_IRQ_STAT, 8'h01);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_STAT, 8'h01);
    rdc(IDX_IRQ_STAT, 8'h00);
  endtask : t_irq

  task automatic t_latch();
    // Low bits keep the earlier latch until the high byte is read again
    wr(IDX_CTRL, 8'h90);
    repeat (260) @(posedge hclk);
    rdc(IDX_IRQ_STAT, 8'h01);
    rdc(IDX_LOW, 8'h80);
    rdc(IDX_HIGH, 8'h55);
    rdc(IDX_LOW, 8'h40);
  endtask : t_latch

  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_ctrl();
    t_conv();
    t_irq();
    t_latch();
    tally_and_finish();
  end

  initial
  begin
    repeat (5000) @(posedge hclk);
    num_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule : testbench
